/* File: gst_pkg.sv */
package gst_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int PRE_W = 3;
    localparam int PHASE_W = 2;

    // register map
    localparam logic [7:0] REG_FLAG = 8'h0C;
    localparam logic [7:0] REG_COUNT_LOW = 8'h0E;
    localparam logic [7:0] REG_COUNT_HIGH = 8'h0F;
    localparam logic [7:0] REG_CTRL = 8'h10;
    localparam logic [7:0] REG_GATE_CTRL = 8'h8F;

    // reset values and the counter's all-ones value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // field layout helpers
    localparam int FLAG_OVF_BIT = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'hFD;
    localparam int GATE_VAL_BIT = 2;

    // instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    // pin sync vector indices
    localparam int PIN_EXT = 0;
    localparam int PIN_XTAL = 1;
    localparam int PIN_SENSE = 2;
    localparam int PIN_GATE = 3;
    localparam int PIN_N = 4;

    typedef enum logic [1:0] {
        GST_SRC_INSTR = 2'h0,
        GST_SRC_SYS   = 2'h1,
        GST_SRC_EXT   = 2'h2,
        GST_SRC_SENSE = 2'h3
    } gst_src_t;

    typedef struct packed {
        gst_src_t   clockSelect;
        logic [1:0] prescaleSelect;
        logic       crystalOscEnable;
        logic       syncDisable;
        logic       unused;
        logic       runBit;
    } gst_ctrl_t;

    typedef struct packed {
        logic       gateEnable;
        logic       gatePolarity;
        logic [2:0] gateMisc;
        logic       gateValue;
        logic [1:0] gateSource;
    } gst_gate_t;

    typedef struct packed {
        logic       extCountPin;
        logic       crystalClk;
        logic       senseOsc;
        logic       gatePin;
    } gst_pins_t;

endpackage

/* File: gst_timer.sv */
`timescale 1ns/10ps
module gst_timer
    import gst_pkg::*;
(
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // register port
    input  wire logic [gst_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [gst_pkg::DATA_W-1:0] regWrData,
    input  wire logic                    regWrStb,
    input  wire logic                    regRdStb,
    output logic      [gst_pkg::DATA_W-1:0] regRdData,
    // pins
    input  wire gst_pkg::gst_pins_t      pins,
    // status
    output logic                         overflowFlag
);
    import gst_pkg::*;

    // pin synchronisers
    logic [PIN_N-1:0] pinMeta_q;
    logic [PIN_N-1:0] pinSync_q;
    logic [PIN_N-1:0] pinRaw;

    // registers and state
    gst_ctrl_t            ctrl_q;
    gst_gate_t            gate_q;
    logic [COUNT_W-1:0]   count_q;
    logic [COUNT_W-1:0]   count_d;
    logic [PRE_W-1:0]     pre_q;
    logic [PRE_W-1:0]     pre_d;
    logic [PHASE_W-1:0]   phase_q;
    logic                 extPrev_q;
    logic                 armed_q;
    logic                 armed_d;
    logic                 pend_q;
    logic                 pend_d;
    logic                 flag_q;
    logic                 flag_d;
    logic [DATA_W-1:0]    rdData_q;
    logic [DATA_W-1:0]    rdData_d;

    assign pinRaw = {pins.gatePin, pins.senseOsc, pins.crystalClk, pins.extCountPin};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end

    // address decode
    wire selFlag  = (regAddr == REG_FLAG);
    wire selLow   = (regAddr == REG_COUNT_LOW);
    wire selHigh  = (regAddr == REG_COUNT_HIGH);
    wire selCtrl  = (regAddr == REG_CTRL);
    wire selGate  = (regAddr == REG_GATE_CTRL);
    wire wrLow    = regWrStb & selLow;
    wire wrHigh   = regWrStb & selHigh;
    wire countWr  = wrLow | wrHigh;
    wire wrCtrl   = regWrStb & selCtrl;
    wire wrGate   = regWrStb & selGate;
    wire flagClr  = regWrStb & selFlag & regWrData[FLAG_OVF_BIT];

    // clock source selection
    wire       runBit      = ctrl_q.runBit;
    wire       isExt       = ctrl_q.clockSelect[1];
    wire       instrTick   = (phase_q == INSTR_LAST);
    wire       gateLevel   = pinSync_q[PIN_GATE];
    wire       gateActive  = (gateLevel == gate_q.gatePolarity);
    // counting is enabled by run, then qualified by the gate when gate enable is set
    wire       countEn     = runBit & (~gate_q.gateEnable | gateActive);
    // pin or crystal under select 10, sensing oscillator under 11
    wire       extLevel    = (ctrl_q.clockSelect == GST_SRC_SENSE) ? pinSync_q[PIN_SENSE] :
                             ctrl_q.crystalOscEnable ? pinSync_q[PIN_XTAL] :
                             pinSync_q[PIN_EXT];
    wire       extRise     = extLevel & ~extPrev_q;
    // a rise only counts once a low level has been seen since arming was lost
    wire       extEvent    = isExt & extRise & armed_q;
    // sync mode holds an edge until the next instruction boundary
    wire       extTick     = ctrl_q.syncDisable ? extEvent :
                             ((pend_q | extEvent) & instrTick);
    wire       srcTick     = isExt ? extTick :
                             (ctrl_q.clockSelect == GST_SRC_SYS) ? 1'b1 : instrTick;
    wire [PRE_W-1:0] preMask = PRE_W'((1 << ctrl_q.prescaleSelect) - 1);
    wire       preDone     = ((pre_q & preMask) == preMask);
    wire       step        = srcTick & countEn & preDone & ~countWr;
    wire       rollover    = step & (count_q == COUNT_ALL_ONES);

    // instruction phase counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + PHASE_W'(1);
        end
    end

    // prescaler: restarts on any count write so the first period is whole
    always_comb begin
        pre_d = pre_q;
        if (countWr) begin
            pre_d = '0;
        end else if (srcTick & countEn) begin
            pre_d = preDone ? '0 : pre_q + PRE_W'(1);
        end
    end

    // edge arming and sync pending
    always_comb begin
        armed_d = armed_q;
        if (countWr | ~runBit) begin
            armed_d = 1'b0;
        end else if (~extLevel) begin
            armed_d = 1'b1;
        end
        pend_d = ~ctrl_q.syncDisable & runBit & (pend_q | extEvent) & ~instrTick;
    end

    // counter next value; a write beats an increment in the same cycle
    always_comb begin
        count_d = count_q;
        if (wrLow) begin
            count_d[7:0] = regWrData;
        end else if (wrHigh) begin
            count_d[15:8] = regWrData;
        end else if (step) begin
            count_d = count_q + COUNT_W'(1);
        end
    end

    // overflow flag: set wins over a clear in the same cycle
    assign flag_d = rollover | (flag_q & ~flagClr);

    // read mux; unmapped addresses read zero
    wire [DATA_W-1:0] gateRead = {gate_q.gateEnable, gate_q.gatePolarity, gate_q.gateMisc,
                                  gateLevel, gate_q.gateSource};
    always_comb begin
        rdData_d = READ_ZERO;
        if (regRdStb) begin
            if (selLow) begin
                rdData_d = count_q[7:0];
            end else if (selHigh) begin
                rdData_d = count_q[15:8];
            end else if (selCtrl) begin
                rdData_d = ctrl_q & CTRL_WR_MASK;
            end else if (selGate) begin
                rdData_d = gateRead;
            end else if (selFlag) begin
                rdData_d = {7'h00, flag_q};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            gate_q <= GATE_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= regWrData & CTRL_WR_MASK;
            end
            if (wrGate) begin
                gate_q <= regWrData;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q   <= COUNT_RESET;
            pre_q     <= '0;
            extPrev_q <= 1'b0;
            armed_q   <= 1'b0;
            pend_q    <= 1'b0;
            flag_q    <= 1'b0;
            rdData_q  <= READ_ZERO;
        end else begin
            count_q   <= count_d;
            pre_q     <= pre_d;
            extPrev_q <= extLevel;
            armed_q   <= armed_d;
            pend_q    <= pend_d;
            flag_q    <= flag_d;
            rdData_q  <= rdData_d;
        end
    end

    assign regRdData    = rdData_q;
    assign overflowFlag = flag_q;

    // checks
    chk_off_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!ctrl_q.runBit && !countWr) |=> (count_q == $past(count_q)))
        else $error("count moved while run bit clear");

    chk_gate_blocks: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ctrl_q.runBit && gate_q.gateEnable && !gateActive && !countWr)
        |=> (count_q == $past(count_q)))
        else $error("count moved while gate inactive");

    chk_write_low: assert property (
        @(posedge sys_clk) disable iff (rst)
        wrLow |=> (count_q[7:0] == $past(regWrData)))
        else $error("low byte write not applied");

    chk_write_high: assert property (
        @(posedge sys_clk) disable iff (rst)
        wrHigh |=> (count_q[15:8] == $past(regWrData) && count_q[7:0] == $past(count_q[7:0])))
        else $error("high byte write not applied");

    chk_sys_rate: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ctrl_q.runBit && !gate_q.gateEnable && ctrl_q.clockSelect == GST_SRC_SYS
         && ctrl_q.prescaleSelect == 2'b00 && !countWr && !wrCtrl && !wrGate)
        |=> (count_q == $past(count_q) + COUNT_W'(1)))
        else $error("system clock source did not count every cycle");

    chk_instr_rate: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step && ctrl_q.clockSelect == GST_SRC_INSTR) |-> (phase_q == INSTR_LAST))
        else $error("instruction source counted off an instruction boundary");

    chk_sync_align: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step && isExt && !ctrl_q.syncDisable) |-> instrTick)
        else $error("synchronised external count not on boundary");

    chk_ext_edge: assert property (
        @(posedge sys_clk) disable iff (rst)
        (extEvent && ctrl_q.syncDisable && ctrl_q.runBit && !gate_q.gateEnable
         && ctrl_q.prescaleSelect == 2'b00 && !countWr)
        |=> (count_q == $past(count_q) + COUNT_W'(1)))
        else $error("external rising edge not counted");

    chk_write_disarms: assert property (
        @(posedge sys_clk) disable iff (rst)
        countWr |=> (!armed_q && !extEvent))
        else $error("edge counter still armed after count write");

    chk_ovf_set: assert property (
        @(posedge sys_clk) disable iff (rst)
        rollover |=> (flag_q && count_q == COUNT_RESET))
        else $error("rollover did not set overflow flag");

    chk_ovf_sticky: assert property (
        @(posedge sys_clk) disable iff (rst)
        (flag_q && !flagClr) |=> flag_q [*2] or (flag_q ##1 $past(flagClr)))
        else $error("overflow flag dropped without a clear");

    chk_read_low: assert property (
        @(posedge sys_clk) disable iff (rst)
        (regRdStb && selLow) |=> (regRdData == $past(count_q[7:0])) ##1 (regRdData == READ_ZERO
         || $past(regRdStb)))
        else $error("low byte read data wrong");

    chk_read_high: assert property (
        @(posedge sys_clk) disable iff (rst)
        (regRdStb && selHigh) |=> (regRdData == $past(count_q[15:8])))
        else $error("high byte read data wrong");

    // an idle port returns zero so software never sees a stale byte
    chk_read_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        !regRdStb |=> (regRdData == READ_ZERO))
        else $error("read data not zero after an idle cycle");

    chk_ctrl_spare: assert property (
        @(posedge sys_clk) disable iff (rst)
        (regRdStb && selCtrl) |=> ((regRdData & ~CTRL_WR_MASK) == READ_ZERO))
        else $error("reserved control bit read as one");

    // a ratio of two leaves at least one idle cycle between steps
    chk_sys_half: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step && ctrl_q.clockSelect == GST_SRC_SYS && ctrl_q.prescaleSelect == 2'h1
         && !wrCtrl) |=> !step)
        else $error("prescale of two counted on consecutive cycles");

    // the phase counter is free running, so three quiet cycles follow every step
    chk_instr_gap: assert property (
        @(posedge sys_clk) disable iff (rst)
        (step && ctrl_q.clockSelect == GST_SRC_INSTR)
        |=> (!step || ctrl_q.clockSelect != GST_SRC_INSTR) [*3])
        else $error("instruction source counted twice within four cycles");

    // arming only ever follows a low level on the selected input
    chk_arm_on_low: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(armed_q) |-> !$past(extLevel))
        else $error("edge counter armed without a low level");

    chk_off_disarms: assert property (
        @(posedge sys_clk) disable iff (rst)
        !runBit |=> !armed_q)
        else $error("edge counter armed while run bit clear");

    chk_unarmed_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        (isExt && ctrl_q.syncDisable && !armed_q && !countWr)
        |=> (count_q == $past(count_q)))
        else $error("external edge counted before a low level");

    chk_ovf_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        (flagClr && !rollover) |=> !flag_q)
        else $error("overflow flag not cleared by a write of one");

    // an overflow that lands on the clearing write must not be lost
    chk_ovf_set_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        (flagClr && rollover) |=> flag_q)
        else $error("clear beat a rollover in the same cycle");

    cov_sync_count: cover property (@(posedge sys_clk) disable iff (rst)
        step && isExt && !ctrl_q.syncDisable);

    cov_overflow: cover property (@(posedge sys_clk) disable iff (rst) rollover);
    cov_ext_count: cover property (@(posedge sys_clk) disable iff (rst) step && isExt);
    cov_gated: cover property (@(posedge sys_clk) disable iff (rst)
        step && gate_q.gateEnable);
    cov_set_clear: cover property (@(posedge sys_clk) disable iff (rst) rollover && flagClr);

endmodule

/* File: gst_pin_model.sv */
`timescale 1ns/10ps
module gst_pin_model
    import gst_pkg::*;
#(
    parameter int XTAL_HALF = 381
)
(
    // clock
    input  wire logic          sys_clk,
    // bench controls
    input  wire logic          xtalOn,
    input  wire logic          gateLvl,
    // pins towards the timer
    output gst_pkg::gst_pins_t pins
);
    logic extLvl;
    logic senseLvl;
    logic xtalLvl;
    int   xtalCnt;

    assign pins = '{extCountPin: extLvl, crystalClk: xtalLvl,
                    senseOsc: senseLvl, gatePin: gateLvl};

    // pin starts high so the first level seen after reset is not a real edge
    initial begin
        extLvl = 1'b1;
        senseLvl = 1'b0;
        xtalLvl = 1'b0;
        xtalCnt = 0;
    end

    // a stopped oscillator rests low; default half period is a 32.768 kHz part at 25 MHz
    always @(posedge sys_clk) begin
        if (!xtalOn) begin
            xtalCnt <= 0;
            xtalLvl <= 1'b0;
        end else if (xtalCnt == XTAL_HALF - 1) begin
            xtalCnt <= 0;
            xtalLvl <= ~xtalLvl;
        end else begin
            xtalCnt <= xtalCnt + 1;
        end
    end

    // low then high, n times; the line is left high between bursts
    task automatic pulse(input logic sense, input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge sys_clk);
            if (sense) senseLvl <= 1'b0; else extLvl <= 1'b0;
            repeat (half) @(posedge sys_clk);
            if (sense) senseLvl <= 1'b1; else extLvl <= 1'b1;
        end
    endtask
endmodule

/* File: gated_sixteen_bit_timer_tb.sv */
`timescale 1ns/10ps
module gated_sixteen_bit_timer_tb;
    import gst_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic [7:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWrStb;
    logic        regRdStb;
    logic [7:0]  regRdData;
    gst_pins_t   pins;
    logic        overflowFlag;
    logic        xtalOn;
    logic        gateLvl;
    int          err_total;
    int          n_compared;
    int          cycles;
    int          expCnt;
    int          n;
    logic [7:0]  rdv;
    logic [15:0] cnt;
    logic [15:0] cnt2;
    logic [7:0]  modes [4] = '{8'h84, 8'h80, 8'hc4, 8'hc0};

    gst_timer gst_timer_inst (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .pins(pins), .overflowFlag(overflowFlag));
    gst_pin_model gst_pin_model_inst (.sys_clk(sys_clk), .xtalOn(xtalOn),
        .gateLvl(gateLvl), .pins(pins));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the run is a few thousand cycles; the ceiling leaves a wide margin
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("unexpected at %0t: run did not finish", $time);
            conclude();
        end
    end

    // tol allows for the unknown phase of prescaler and strobe latency
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input int tol);
        n_compared++;
        if ((^g === 1'bx) || (int'(g) > int'(e) + tol) || (int'(g) + tol < int'(e))) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
        @(posedge sys_clk);
        #1 chk({8'h00, regRdData}, 16'h0000, 0);
    endtask

    task automatic setCount(input logic [15:0] v);
        wr(REG_COUNT_LOW, v[7:0]);
        wr(REG_COUNT_HIGH, v[15:8]);
    endtask

    // called while stopped or while the edge counter is still unarmed, so the two byte reads cannot tear
    task automatic getCount(output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(REG_COUNT_LOW, lo);
        rd(REG_COUNT_HIGH, hi);
        c = {hi, lo};
    endtask

    task automatic runFor(input logic [7:0] c, input int k);
        wr(REG_CTRL, c | 8'h01);
        repeat (k) @(posedge sys_clk);
        wr(REG_CTRL, c);
    endtask

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        xtalOn = 1'b0;
        gateLvl = 1'b1;
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        void'($urandom(91839));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(REG_CTRL, rdv);
        chk({8'h00, rdv}, {8'h00, CTRL_RESET}, 0);
        rd(REG_GATE_CTRL, rdv);
        chk({8'h00, rdv}, 16'h0004, 0);
        rd(8'h55, rdv);
        chk({8'h00, rdv}, 16'h0000, 0);
        // pin high since reset: nothing counts until a low has been seen
        wr(REG_CTRL, 8'h85);
        repeat (12) @(posedge sys_clk);
        getCount(cnt);
        chk(cnt, 16'h0000, 0);
        gst_pin_model_inst.pulse(1'b0, 3, 6);
        repeat (8) @(posedge sys_clk);
        wr(REG_CTRL, 8'h84);
        getCount(cnt);
        chk(cnt, 16'h0003, 0);
        // random direct write, reserved control bit reads zero
        cnt2 = 16'($urandom);
        setCount(cnt2);
        getCount(cnt);
        chk(cnt, cnt2, 0);
        wr(REG_CTRL, 8'h3e);
        rd(REG_CTRL, rdv);
        chk({8'h00, rdv}, 16'h003c, 0);
        // both internal sources at every prescale ratio
        for (int cs = 0; cs < 2; cs++) begin
            for (int ps = 0; ps < 4; ps++) begin
                setCount(16'h0000);
                runFor({cs[1:0], ps[1:0], 4'h0}, 62);
                getCount(cnt);
                expCnt = (64 >> ps) / ((cs == 0) ? INSTR_DIV : 1);
                chk(cnt, 16'(expCnt), 1);
            end
        end
        // gate closed, then open, then run off with gate open
        wr(REG_GATE_CTRL, 8'h80);
        setCount(16'h0000);
        runFor(8'h40, 30);
        getCount(cnt);
        chk(cnt, 16'h0000, 0);
        @(posedge sys_clk);
        gateLvl <= 1'b0;
        repeat (4) @(posedge sys_clk);
        runFor(8'h40, 30);
        getCount(cnt);
        chk(cnt, 16'h0020, 1);
        repeat (20) @(posedge sys_clk);
        getCount(cnt2);
        chk(cnt2, cnt, 0);
        // polarity one makes the low gate pin inactive
        wr(REG_GATE_CTRL, 8'hc0);
        rd(REG_GATE_CTRL, rdv);
        chk({8'h00, rdv}, 16'h00c0, 0);
        runFor(8'h40, 30);
        getCount(cnt2);
        chk(cnt2, cnt, 0);
        wr(REG_GATE_CTRL, 8'h00);
        // rollover sets a sticky flag that a write of one clears
        chk({15'h0000, overflowFlag}, 16'h0000, 0);
        setCount(16'hfff0);
        runFor(8'h40, 30);
        getCount(cnt);
        chk(cnt, 16'h0010, 1);
        rd(REG_FLAG, rdv);
        chk({8'h00, rdv}, 16'h0001, 0);
        chk({15'h0000, overflowFlag}, 16'h0001, 0);
        wr(REG_FLAG, 8'h01);
        #1 chk({15'h0000, overflowFlag}, 16'h0000, 0);
        // a rollover on the very cycle of a clear must leave the flag set
        setCount(16'hffff);
        @(posedge sys_clk);
        regAddr <= REG_CTRL;
        regWrData <= 8'h41;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regAddr <= REG_FLAG;
        regWrData <= 8'h01;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        wr(REG_CTRL, 8'h40);
        #1 chk({15'h0000, overflowFlag}, 16'h0001, 0);
        wr(REG_FLAG, 8'h01);
        // pin and sensing oscillator, asynchronous and synchronised
        foreach (modes[i]) begin
            setCount(16'h0000);
            wr(REG_CTRL, modes[i] | 8'h01);
            n = $urandom_range(9, 2);
            gst_pin_model_inst.pulse(modes[i][6], n, 6);
            repeat (10) @(posedge sys_clk);
            wr(REG_CTRL, modes[i]);
            getCount(cnt);
            chk(cnt, 16'(n), 0);
        end
        // crystal as a timer base
        setCount(16'h0000);
        @(posedge sys_clk);
        xtalOn <= 1'b1;
        runFor(8'h8c, 2286);
        xtalOn <= 1'b0;
        getCount(cnt);
        chk(cnt, 16'h0003, 1);
        conclude();
    end
endmodule
